// file: rtl/swc_pkg.sv
// Constants and types shared by the sleep and wake controller
`default_nettype none
package swc_pkg;
  // Register byte offsets on the bus
  localparam logic [5:0] OFS_INTCTL = 6'h00;
  localparam logic [5:0] OFS_PERIPH_IRQ_ENABLE_1   = 6'h04;
  localparam logic [5:0] OFS_PERIPH_IRQ_ENABLE_2   = 6'h08;
  localparam logic [5:0] OFS_PERIPH_IRQ_ENABLE_3   = 6'h0c;
  localparam logic [5:0] OFS_PERIPH_IRQ_FLAG_1   = 6'h10;
  localparam logic [5:0] OFS_PERIPH_IRQ_FLAG_2   = 6'h14;
  localparam logic [5:0] OFS_PERIPH_IRQ_FLAG_3   = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;
  localparam logic [5:0] OFS_CTRL   = 6'h20;
  // Implemented bit masks of enable and flag registers
  localparam logic [7:0] MASK_INTCTL = 8'hff;
  localparam logic [7:0] MASK_P1     = 8'hcf;
  localparam logic [7:0] MASK_P2     = 8'h09;
  localparam logic [7:0] MASK_P3     = 8'h10;
  localparam logic [7:0] MASK_STATUS = 8'h07;
  localparam logic [7:0] MASK_CTRL   = 8'h0f;
  // Interrupt control fields
  localparam int GIE_BIT  = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int CORE_EN_LSB = 3;
  // Status fields
  localparam int PD_BIT    = 0;
  localparam int TO_BIT    = 1;
  localparam int ASLP_BIT  = 2;
  // Control fields
  localparam int WDT_EN_BIT   = 0;
  localparam int WDT_SLP_BIT  = 1;
  localparam int XRST_EN_BIT  = 2;
  localparam int LSR_EN_BIT   = 3;
  // Reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h0c;
  // Timer1 clock source codes
  localparam logic [1:0] T1_SYS    = 2'h0;
  localparam logic [1:0] T1_SLOW   = 2'h1;
  localparam logic [1:0] T1_EXT    = 2'h2;
  localparam logic [1:0] T1_SEC    = 2'h3;
  // Watchdog period in slow oscillator ticks
  localparam logic [15:0] WDT_TICKS_DEF = 16'h0400;
  typedef enum logic {SWC_RUN, SWC_SLEEP} swc_state_t;
endpackage
`default_nettype wire

// file: rtl/swc_top.sv
// Sleep entry, wake decision and interrupt flag registers
//
// Notes on behaviour
// - Flags set on their event regardless of enables or global enable.
// - Unimplemented enable and flag bits read as zero.
// - Sleep is entered only by the core's sleep instruction.
// - Watchdog cleared on sleep entry, keeps counting if sleep-enabled.
// - Sleep entry clears power-down flag and sets watchdog-expired flag.
// - Core clock is gated off while asleep.
// - Slow internal oscillator keeps running during sleep.
// - Timer1 runs in sleep on slow, external or secondary clock.
// - Converter runs in sleep on its dedicated oscillator.
// - Pins hold their pre-sleep drive state while asleep.
// - Non-watchdog resets behave normally during sleep.
// - Wake on pin, supply, power-on reset, watchdog or enabled interrupt.
// - Reset sources reset the device; watchdog and interrupts resume.
// - The following instruction is prefetched during sleep execution.
// - Individual enable gates wake; global enable does not.
// - Global enable clear: resume after the sleep instruction.
// - Global enable set: run next instruction, then vector.
// - Watchdog cleared on every wake.
// - Pending interrupt makes sleep a no-op with no side effects.
//
// Register map, one 8-bit register in the low byte of each word
//   0x00 interrupt control
//        b7 global enable, b6 peripheral enable
//        b5..b3 core source enables, paired with flags b2..b0
//   0x04 peripheral enables, slot 1 (bits 7, 6, 3..0)
//   0x08 peripheral enables, slot 2 (bits 3 and 0)
//   0x0c peripheral enables, slot 3 (bit 4)
//   0x10 peripheral flags, slot 1, same bits as its enables
//   0x14 peripheral flags, slot 2, same bits as its enables
//   0x18 peripheral flags, slot 3, same bits as its enables
//   0x1c status, read only
//        b0 power-down flag, low once a sleep was taken
//        b1 watchdog-expired flag, low after a watchdog expiry, awake or asleep
//        b2 asleep, high while the core clock is stopped
//   0x20 control, resets to pin and supply resets enabled
//        b0 watchdog enable, b1 watchdog keeps counting asleep
//        b2 reset pin enable, b3 supply reset enable
//        Any write here also restarts the watchdog count
//   Other offsets read zero and drop writes.
//
// Bus timing
//   Every access takes exactly one wait cycle. Read data are
//   captured in the wait cycle and stand when waitrequest drops;
//   a write lands on the edge at which waitrequest is low.
//   Back-to-back requests each pay the wait cycle again.
//
// Core handshake
//   sleep_exec is sampled only while the core clock runs.
//   prefetch_next, sleep_nop, wake_resume and wake_then_vector are
//   one-cycle pulses, registered one edge after their cause.
//   core_clk_en drops the cycle after sleep is taken and rises
//   the cycle after the wake edge, so no partial cycle reaches
//   the core.
//
// Flags and enables
//   A hardware set and a software write in one cycle: the set
//   wins, so an event is never lost to a clearing write.
//   Wake looks only at flag and individual enable; the interrupt
//   line to the core also needs the global enable, plus the peripheral enable for slot flags.
//
// Limitations
//   The watchdog period is a parameter counted in slow ticks, not
//   a register. Reset sources are level inputs taken as synchronous
//   to mclk; whoever drives them must already be in this domain.
//   Pin state is held by freezing the pin registers, not latches.
//   The timer1 and converter clock enables only say which clocks
//   may run asleep; the clock muxes themselves sit elsewhere.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
module swc_top #(
  parameter logic [15:0] WDT_TICKS = swc_pkg::WDT_TICKS_DEF
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_exec,
  output logic             core_clk_en,
  output logic             prefetch_next,
  output logic             sleep_nop,
  output logic             wake_resume,
  output logic             wake_then_vector,
  output logic             core_irq,
  input  wire logic [2:0]  core_evt,
  input  wire logic [7:0]  periph_evt_1,
  input  wire logic [7:0]  periph_evt_2,
  input  wire logic [7:0]  periph_evt_3,
  input  wire logic        slow_osc_tick,
  output logic             slow_osc_run,
  input  wire logic [1:0]  timer1_src,
  output logic             timer1_clk_en,
  input  wire logic        adc_on_dedicated_osc,
  output logic             adc_clk_en,
  input  wire logic        external_reset_pin_n,
  input  wire logic        low_supply_reset,
  input  wire logic        power_on_reset,
  output logic             device_reset,
  input  wire logic [7:0]  io_out_core,
  input  wire logic [7:0]  io_oe_core,
  output logic [7:0]       io_out,
  output logic [7:0]       io_oe
);
  import swc_pkg::*;

  swc_state_t  state_q;
  logic [7:0]  intctl_q, periph_irq_enable_1_q, periph_irq_enable_2_q, periph_irq_enable_3_q;
  logic [7:0]  periph_irq_flag_1_q, periph_irq_flag_2_q, periph_irq_flag_3_q;
  logic [7:0]  ctrl_q;
  logic        pd_q, to_q;
  logic [15:0] wdt_q;
  logic        ack_q;
  logic        acc, wr_go;
  logic        core_pend, periph_pend, pending;
  logic        wdt_run, wdt_hit, reset_src;
  logic        enter, wake_irq, wake_wdt;
  logic [7:0]  rd_byte;

  // Flag update: a set on the same edge as a write wins
  function automatic logic [7:0] flag_next(
    input logic [7:0] cur,
    input logic       we,
    input logic [7:0] wval,
    input logic [7:0] evt,
    input logic [7:0] mask
  );
    logic [7:0] base;
    base = we ? wval : cur;
    return (base | evt) & mask;
  endfunction

  // Enable and flag pairs used more than once
  function automatic logic any_hit(
    input logic [7:0] en,
    input logic [7:0] fl
  );
    return |(en & fl);
  endfunction

  // Bus: one wait cycle, then the access completes
  assign acc             = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_q;
  assign wr_go           = avs_write & ack_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end

  // Wake request computed without any clock gating in its path
  assign core_pend   = any_hit({5'h00, intctl_q[5:CORE_EN_LSB]},
                               {5'h00, intctl_q[2:0]});
  assign periph_pend = any_hit(periph_irq_enable_1_q, periph_irq_flag_1_q) |
                       any_hit(periph_irq_enable_2_q, periph_irq_flag_2_q) |
                       any_hit(periph_irq_enable_3_q, periph_irq_flag_3_q);
  assign pending     = core_pend | periph_pend;

  // Interrupt line to core needs global enable; slot sources also need peripheral enable
  assign core_irq = intctl_q[GIE_BIT] &
                    (core_pend | (intctl_q[PERIPHERAL_IRQ_ENABLE_BIT] & periph_pend));

  // Resets other than the watchdog pass straight through
  assign reset_src = (~external_reset_pin_n & ctrl_q[XRST_EN_BIT]) |
                     (low_supply_reset & ctrl_q[LSR_EN_BIT]) |
                     power_on_reset;

  // Watchdog counts on slow ticks; in sleep only if allowed
  assign wdt_run = ctrl_q[WDT_EN_BIT] &
                   ((state_q == SWC_RUN) | ctrl_q[WDT_SLP_BIT]);
  assign wdt_hit = wdt_run & slow_osc_tick & (wdt_q == WDT_TICKS - 16'h1);

  // Sleep is entered only by the instruction, never by pending work
  assign enter    = (state_q == SWC_RUN) & sleep_exec & ~pending;
  assign wake_irq = (state_q == SWC_SLEEP) & pending;
  assign wake_wdt = (state_q == SWC_SLEEP) & wdt_hit;

  // Power state machine
  always_ff @(posedge mclk) begin
    if (sys_rst || reset_src) begin
      state_q <= SWC_RUN;
    end else begin
      case (state_q)
        SWC_RUN: begin
          if (enter) begin
            state_q <= SWC_SLEEP;
          end
        end
        SWC_SLEEP: begin
          if (wake_irq || wake_wdt) begin
            state_q <= SWC_RUN;
          end
        end
        default: state_q <= SWC_RUN;
      endcase
    end
  end

  // Core handshakes, one-cycle pulses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prefetch_next    <= 1'b0;
      sleep_nop        <= 1'b0;
      wake_resume      <= 1'b0;
      wake_then_vector <= 1'b0;
    end else begin
      prefetch_next    <= (state_q == SWC_RUN) & sleep_exec;
      sleep_nop        <= (state_q == SWC_RUN) & sleep_exec &
                          pending;
      wake_resume      <= (wake_irq | wake_wdt) & ~reset_src;
      wake_then_vector <= wake_irq & ~reset_src &
                          intctl_q[GIE_BIT];
    end
  end

  // Core clock gate; held off until the wake edge
  assign core_clk_en = (state_q == SWC_RUN);

  // Clocks that survive sleep
  assign slow_osc_run  = 1'b1;
  assign timer1_clk_en = (state_q == SWC_RUN) |
                         (timer1_src == T1_SLOW) |
                         (timer1_src == T1_EXT) |
                         (timer1_src == T1_SEC);
  assign adc_clk_en    = (state_q == SWC_RUN) | adc_on_dedicated_osc;

  // Awake watchdog expiry resets the device
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= reset_src |
                      (wdt_hit & (state_q == SWC_RUN));
    end
  end

  // Watchdog counter
  always_ff @(posedge mclk) begin
    if (sys_rst || reset_src) begin
      wdt_q <= 16'h0000;
    end else if (enter || wake_irq || wake_wdt) begin
      wdt_q <= 16'h0000;
    end else if (wr_go && avs_address == OFS_CTRL) begin
      wdt_q <= 16'h0000;
    end else if (wdt_run && slow_osc_tick) begin
      wdt_q <= wdt_hit ? 16'h0000 : wdt_q + 16'h1;
    end
  end

  // Status flags: active-low power-down and watchdog-expired
  always_ff @(posedge mclk) begin
    if (sys_rst || power_on_reset) begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end else if (enter) begin
      pd_q <= 1'b0;
      to_q <= 1'b1;
    end else if (wdt_hit) begin
      to_q <= 1'b0;
    end
  end

  // Interrupt control register; low three bits are flags
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intctl_q <= RST_REG;
    end else begin
      intctl_q <= flag_next(intctl_q,
                            wr_go && avs_address == OFS_INTCTL,
                            avs_writedata[7:0], {5'h00, core_evt},
                            MASK_INTCTL);
    end
  end

  // Enable and flag registers of the three peripheral slots
  // One loop keeps the three slots identical; only masks differ
  localparam logic [7:0] SLOT_MASK [3] = '{MASK_P1, MASK_P2, MASK_P3};
  localparam logic [5:0] SLOT_PIE  [3] = '{OFS_PERIPH_IRQ_ENABLE_1, OFS_PERIPH_IRQ_ENABLE_2, OFS_PERIPH_IRQ_ENABLE_3};
  localparam logic [5:0] SLOT_PIR  [3] = '{OFS_PERIPH_IRQ_FLAG_1, OFS_PERIPH_IRQ_FLAG_2, OFS_PERIPH_IRQ_FLAG_3};
  logic [7:0] slot_evt [3];
  logic [7:0] slot_en  [3];
  logic [7:0] slot_fl  [3];

  // Event inputs gathered per slot
  assign slot_evt[0] = periph_evt_1;
  assign slot_evt[1] = periph_evt_2;
  assign slot_evt[2] = periph_evt_3;

  for (genvar i = 0; i < 3; i++) begin : g_slot
    // Enable register; unimplemented bits never stored
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        slot_en[i] <= RST_REG;
      end else if (wr_go && avs_address == SLOT_PIE[i]) begin
        slot_en[i] <= avs_writedata[7:0] & SLOT_MASK[i];
      end
    end
    // Flag register, set by its events at any time
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        slot_fl[i] <= RST_REG;
      end else begin
        slot_fl[i] <= flag_next(slot_fl[i],
                                wr_go && avs_address == SLOT_PIR[i],
                                avs_writedata[7:0], slot_evt[i],
                                SLOT_MASK[i]);
      end
    end
  end

  // Named views for wake logic and read mux
  assign periph_irq_enable_1_q = slot_en[0];
  assign periph_irq_enable_2_q = slot_en[1];
  assign periph_irq_enable_3_q = slot_en[2];
  assign periph_irq_flag_1_q = slot_fl[0];
  assign periph_irq_flag_2_q = slot_fl[1];
  assign periph_irq_flag_3_q = slot_fl[2];

  // Control register: watchdog and reset-source enables
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_go && avs_address == OFS_CTRL) begin
      ctrl_q <= avs_writedata[7:0] & MASK_CTRL;
    end
  end

  // Pins freeze at the last awake value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      io_out <= 8'h00;
      io_oe  <= 8'h00;
    end else if (state_q == SWC_RUN && !enter) begin
      io_out <= io_out_core;
      io_oe  <= io_oe_core;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (avs_address)
      OFS_INTCTL: rd_byte = intctl_q;
      OFS_PERIPH_IRQ_ENABLE_1:   rd_byte = periph_irq_enable_1_q;
      OFS_PERIPH_IRQ_ENABLE_2:   rd_byte = periph_irq_enable_2_q;
      OFS_PERIPH_IRQ_ENABLE_3:   rd_byte = periph_irq_enable_3_q;
      OFS_PERIPH_IRQ_FLAG_1:   rd_byte = periph_irq_flag_1_q;
      OFS_PERIPH_IRQ_FLAG_2:   rd_byte = periph_irq_flag_2_q;
      OFS_PERIPH_IRQ_FLAG_3:   rd_byte = periph_irq_flag_3_q;
      OFS_STATUS: rd_byte = {5'h00, state_q == SWC_SLEEP, to_q, pd_q};
      OFS_CTRL:   rd_byte = ctrl_q;
      default:    rd_byte = 8'h00;
    endcase
  end

  // Read data captured in the wait cycle, stands at completion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end
endmodule
`default_nettype wire

// file: verif/swc_asserts.sv
// Port checks for the sleep and wake controller
`default_nettype none
module swc_asserts
  import swc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       sleep_exec,
  input wire logic       core_clk_en,
  input wire logic       prefetch_next,
  input wire logic       sleep_nop,
  input wire logic       wake_resume,
  input wire logic       wake_then_vector,
  input wire logic [1:0] timer1_src,
  input wire logic       timer1_clk_en,
  input wire logic       adc_on_dedicated_osc,
  input wire logic       adc_clk_en,
  input wire logic       slow_osc_run,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Bus slave answers after one wait cycle
  bus_wait_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait wrong");
  sleep_pref_a: assert property (core_clk_en && sleep_exec |=>
    prefetch_next) else $error("no prefetch");
  sleep_only_a: assert property ($fell(core_clk_en) |->
    $past(sleep_exec)) else $error("sleep without instruction");
  core_gate_a: assert property (prefetch_next && !sleep_nop |->
    !core_clk_en) else $error("core clock not gated");
  nop_awake_a: assert property (sleep_nop |-> core_clk_en)
    else $error("no-op sleep stopped core");
  // Pins frozen whenever the previous cycle was asleep
  io_hold_a: assert property (!$past(core_clk_en) |->
    $stable(io_out) && $stable(io_oe)) else $error("pins moved asleep");
  t1_clk_a: assert property (timer1_clk_en ==
    (core_clk_en || timer1_src != T1_SYS)) else $error("timer1 clock");
  adc_clk_a: assert property (adc_clk_en ==
    (core_clk_en || adc_on_dedicated_osc)) else $error("adc clock");
  slow_osc_a: assert property (slow_osc_run)
    else $error("slow osc stopped");
  wake_pair_a: assert property (wake_resume |->
    $rose(core_clk_en)) else $error("resume without wake");
  vector_a: assert property (wake_then_vector |-> wake_resume)
    else $error("vector without resume");
endmodule
bind swc_top swc_asserts i_swc_asserts (.mclk, .sys_rst, .avs_read,
  .avs_write, .avs_waitrequest, .sleep_exec, .core_clk_en, .prefetch_next,
  .sleep_nop, .wake_resume, .wake_then_vector, .timer1_src, .timer1_clk_en,
  .adc_on_dedicated_osc, .adc_clk_en, .slow_osc_run, .io_out, .io_oe);
`default_nettype wire

// file: verif/swc_core_model.sv
// Behavioural processor core issuing sleep and driving port latches
`default_nettype none
module swc_core_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       go,
  input  wire logic       core_clk_en,
  output var  logic       sleep_exec,
  output var  logic [7:0] io_out_core,
  output var  logic [7:0] io_oe_core
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only a running core can execute the sleep instruction
  // The modelled program keeps a no-op right after sleep
  always_ff @(posedge mclk) begin
    sleep_exec <= !sys_rst && go && core_clk_en;
  end
  // Latches on the free clock, so any motion asleep must be masked
  always_ff @(posedge mclk) begin
    io_out_core <= sys_rst ? 8'h00 : io_out_core + 8'h01;
    io_oe_core  <= sys_rst ? 8'h00 : io_oe_core ^ 8'h5a;
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the sleep and wake controller
`default_nettype none
module testbench;
  import swc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } swc_row_t;
  // Write then read back; unmapped and unimplemented bits give zero
  localparam swc_row_t ROWS [15] = '{
    '{OFS_PERIPH_IRQ_ENABLE_1, 8'hff, 8'hcf}, '{OFS_PERIPH_IRQ_ENABLE_2, 8'hff, 8'h09},
    '{OFS_PERIPH_IRQ_ENABLE_3, 8'hff, 8'h10}, '{OFS_PERIPH_IRQ_FLAG_1, 8'hff, 8'hcf},
    '{OFS_PERIPH_IRQ_FLAG_2, 8'hff, 8'h09}, '{OFS_PERIPH_IRQ_FLAG_3, 8'hff, 8'h10},
    '{6'h3c, 8'hff, 8'h00}, '{OFS_INTCTL, 8'hff, 8'hff},
    '{OFS_INTCTL, 8'h00, 8'h00}, '{OFS_PERIPH_IRQ_ENABLE_1, 8'h00, 8'h00},
    '{OFS_PERIPH_IRQ_ENABLE_2, 8'h00, 8'h00}, '{OFS_PERIPH_IRQ_ENABLE_3, 8'h00, 8'h00},
    '{OFS_PERIPH_IRQ_FLAG_1, 8'h00, 8'h00}, '{OFS_PERIPH_IRQ_FLAG_2, 8'h00, 8'h00},
    '{OFS_PERIPH_IRQ_FLAG_3, 8'h00, 8'h00}};
  logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  periph_evt_1, periph_evt_2, periph_evt_3;
  logic [7:0]  io_out_core, io_oe_core;
  logic [2:0]  core_evt;
  logic [1:0]  timer1_src;
  logic        sleep_exec, core_clk_en, sleep_nop, wake_resume, go, clr;
  logic        wake_then_vector, device_reset, slow_osc_tick;
  logic        adc_on_dedicated_osc, external_reset_pin_n;
  logic        low_supply_reset, power_on_reset;
  logic [3:0]  seen;
  int          errors, checked;
  swc_top #(.WDT_TICKS(16'h0004)) i_swc_top (
    .mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .sleep_exec, .core_clk_en,
    .prefetch_next(), .sleep_nop, .wake_resume, .wake_then_vector,
    .core_irq(), .core_evt, .periph_evt_1, .periph_evt_2, .periph_evt_3,
    .slow_osc_tick, .slow_osc_run(), .timer1_src, .timer1_clk_en(),
    .adc_on_dedicated_osc, .adc_clk_en(), .external_reset_pin_n,
    .low_supply_reset, .power_on_reset, .device_reset, .io_out_core,
    .io_oe_core, .io_out(), .io_oe());
  swc_core_model i_swc_core_model (.mclk, .sys_rst, .go, .core_clk_en,
    .sleep_exec, .io_out_core, .io_oe_core);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Sticky record of one-cycle answers: nop, resume, vector, reset
  always @(posedge mclk) begin
    seen <= (clr || sys_rst) ? 4'h0 : seen | {device_reset === 1'b1,
      wake_then_vector === 1'b1, wake_resume === 1'b1, sleep_nop === 1'b1};
  end
  task automatic test_done;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic nap;
    @(posedge mclk);
    clr <= 1'b1;
    go <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    go <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wait_run;
    repeat (60) if (core_clk_en !== 1'b1) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      slow_osc_tick <= 1'b1;
      @(posedge mclk);
      slow_osc_tick <= 1'b0;
      @(posedge mclk);
    end
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    test_done();
  end
  initial begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    sys_rst = 1'b1;
    {periph_evt_1, periph_evt_2, periph_evt_3, core_evt} = '0;
    {timer1_src, adc_on_dedicated_osc, slow_osc_tick, go} = '0;
    {low_supply_reset, power_on_reset, errors, checked} = '0;
    external_reset_pin_n = 1'b1;
    clr = 1'b0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(0, OFS_STATUS, 0, q); chk("status", 32'h3, q);
    bus(0, OFS_CTRL, 0, q); chk("ctrl", 32'hc, q);
    foreach (ROWS[i]) begin
      bus(1, ROWS[i].a, ROWS[i].d, q);
      bus(0, ROWS[i].a, 0, q); chk("reg", {24'h0, ROWS[i].e}, q);
    end
    // Events with every enable clear still set implemented flags; slot 3 bit 0 stays zero
    periph_evt_2 <= 8'h08;
    periph_evt_3 <= 8'h01;
    core_evt <= 3'h1;
    @(posedge mclk);
    {periph_evt_2, periph_evt_3, core_evt} <= '0;
    bus(0, OFS_PERIPH_IRQ_FLAG_2, 0, q); chk("periph_irq_flag_2", 32'h8, q);
    bus(0, OFS_PERIPH_IRQ_FLAG_3, 0, q); chk("periph_irq_flag_3", 32'h0, q);
    bus(0, OFS_INTCTL, 0, q); chk("intctl", 32'h1, q);
    bus(1, OFS_INTCTL, 8'h40, q);
    // Already pending: sleep is a no-op, status untouched
    bus(1, OFS_PERIPH_IRQ_ENABLE_2, 8'h08, q);
    nap(); chk("nop", 1, seen[0]);
    chk("awake", 1, core_clk_en);
    bus(0, OFS_STATUS, 0, q); chk("nop status", 32'h3, q);
    bus(1, OFS_PERIPH_IRQ_ENABLE_2, 0, q);
    // Interrupt wake with global enable off, then on
    for (int g = 0; g < 2; g++) begin
      bus(1, OFS_PERIPH_IRQ_FLAG_1, 0, q);
      bus(1, OFS_PERIPH_IRQ_ENABLE_1, 8'h01, q);
      bus(1, OFS_INTCTL, {g[0], 7'h40}, q);
      nap(); chk("asleep", 0, core_clk_en);
      bus(0, OFS_STATUS, 0, q); chk("sleep status", 32'h6, q);
      adc_on_dedicated_osc <= g[0];
      for (int s = 0; s < 4; s++) begin
        timer1_src <= 2'(s);
        @(posedge mclk);
      end
      periph_evt_1 <= 8'h01;
      @(posedge mclk);
      periph_evt_1 <= 8'h00;
      wait_run(); chk("resume", 1, seen[1]);
      chk("vector", g[0], seen[2]);
    end
    // Watchdog cleared on entry, runs asleep, wakes, cleared again
    bus(1, OFS_PERIPH_IRQ_ENABLE_1, 0, q);
    bus(1, OFS_INTCTL, 8'h40, q);
    bus(1, OFS_CTRL, 8'h0f, q);
    tick(3);
    nap();
    periph_evt_1 <= 8'h01;
    @(posedge mclk);
    periph_evt_1 <= 8'h00;
    tick(3); chk("wdt asleep", 0, core_clk_en);
    repeat (3) if (core_clk_en !== 1'b1) tick(1);
    wait_run(); chk("wdt wake", 1, seen[1]);
    tick(3); chk("wdt cleared", 0, seen[3]);
    bus(1, OFS_CTRL, 8'h0c, q);
    // Pin and supply resets wake by full reset, not by resuming
    for (int k = 0; k < 2; k++) begin
      nap(); chk("asleep rst", 0, core_clk_en);
      {low_supply_reset, external_reset_pin_n} <= k ? 2'b11 : 2'b00;
      repeat (3) @(posedge mclk);
      {low_supply_reset, external_reset_pin_n} <= 2'b01;
      wait_run(); chk("reset wake", 1, seen[3]);
      chk("no resume", 0, seen[1]);
    end
    test_done();
  end
endmodule
`default_nettype wire
